// >>> include/slfm_pkg.sv
`default_nettype none
package slfm_pkg;
    // link modes handled by the mapper
    localparam logic [3:0] SLFM_MODE0 = 4'h0;
    localparam logic [3:0] SLFM_MODE1 = 4'h1;
    localparam logic [3:0] SLFM_MODE2 = 4'h2;
    localparam logic [3:0] SLFM_MODE3 = 4'h3;
    localparam logic [3:0] SLFM_MODE4 = 4'h4;
    localparam logic [3:0] SLFM_MODE5 = 4'h5;
    localparam logic [3:0] SLFM_MODE6 = 4'h6;
    // channel count variants
    localparam logic [1:0] SLFM_VAR_SINGLE = 2'h0;
    localparam logic [1:0] SLFM_VAR_DUAL   = 2'h1;
    localparam logic [1:0] SLFM_VAR_QUAD   = 2'h2;
    localparam int SLFM_LANES    = 8;
    localparam int SLFM_CHANS    = 4;
    localparam int SLFM_SPC      = 10;  // samples per channel per input beat
    localparam int SLFM_FRAME_W  = 64;  // widest frame: eight octets
    localparam int SLFM_FIFO_DEP = 8;
    localparam logic [3:0]  SLFM_TAIL   = 4'h0;
    localparam logic [7:0]  SLFM_FILL8  = 8'h00;
    localparam logic [3:0]  SLFM_FILL4  = 4'h0;

    typedef logic [11:0] slfm_smp_t;
    // one input beat: up to ten samples of each channel, msb-aligned 12-bit
    typedef struct packed {
        slfm_smp_t [SLFM_CHANS-1:0][SLFM_SPC-1:0] smp;
    } slfm_beat_t;
    // one mapped frame on every lane, octet 0 in the top bits
    typedef struct packed {
        logic [SLFM_LANES-1:0]                     lane_en;
        logic [SLFM_LANES-1:0][SLFM_FRAME_W-1:0]  lane;
    } slfm_frame_t;
endpackage : slfm_pkg
`default_nettype wire

// >>> rtl/slfm_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module slfm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } slfm_fifo_st_t;
    slfm_fifo_st_t st, next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    // honest flags straight from the count
    assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st.cnt != '0);
    assign out_data  = mem[st.rp];
    assign push = in_valid && in_ready;
    assign pop  = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) next_st.wp = st.wp + 1'b1;
        if (pop)  next_st.rp = st.rp + 1'b1;
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) st <= '0;
        else        st <= next_st;
    end

    // storage has no reset, only pointers and count do
    always_ff @(posedge clk_sys) begin
        if (push) mem[st.wp] <= in_data;
    end
endmodule : slfm_fifo
`default_nettype wire

// >>> rtl/slfm_mapper.sv
`timescale 1ns/10ps
`default_nettype none
module slfm_mapper
    import slfm_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire logic [3:0]             link_mode_select,
    input  wire logic [1:0]             chan_variant,
    input  wire slfm_beat_t             smp_data,
    input  wire logic                   smp_valid,
    output logic                        smp_ready,
    input  wire logic                   frame_ready,
    output logic                        frame_valid,
    output logic [SLFM_LANES-1:0]       lane_enable,
    output logic [SLFM_LANES-1:0][SLFM_FRAME_W-1:0] lane_data
);
    ////////////////////////////////////////////////////////////////////////////
    // mirror of the buffer fill, wide enough to hold the full depth
    localparam int               OCC_W    = $clog2(SLFM_FIFO_DEP) + 1;
    localparam logic [OCC_W-1:0] OCC_FULL = OCC_W'(SLFM_FIFO_DEP);

    // output flop, buffer fill mirror and registered ready in one state word
    typedef struct packed {
        logic             out_vld;
        slfm_frame_t      out;
        logic [OCC_W-1:0] used;
        logic             in_rdy;
    } slfm_st_t;
    // reset leaves the pipe empty but ready, so a beat may come at the first edge
    localparam slfm_st_t ST_IDLE = '{out_vld: 1'b0, out: '0, used: '0, in_rdy: 1'b1};
    slfm_st_t    st, next_st;
    slfm_frame_t map_frame, fifo_frame;
    logic        fifo_valid, fifo_pop, take;

    // sample helpers; the 10- and 8-bit forms take the upper bits
    function automatic slfm_smp_t s12(input slfm_beat_t b, input int c, input int n);
        s12 = b.smp[c][n];
    endfunction : s12
    function automatic logic [9:0] s10(input slfm_beat_t b, input int c, input int n);
        s10 = b.smp[c][n][11:2];
    endfunction : s10
    function automatic logic [7:0] s8(input slfm_beat_t b, input int c, input int n);
        s8 = b.smp[c][n][11:4];
    endfunction : s8
    // channel present in this variant; absent channels go out as zero fill
    // variant code 3 falls to the single case, the safest reading
    function automatic logic chan_on(input logic [1:0] v, input int c);
        unique case (v)
            SLFM_VAR_QUAD: chan_on = (c < SLFM_CHANS);
            SLFM_VAR_DUAL: chan_on = (c < 2);
            default:       chan_on = (c < 1);
        endcase
    endfunction : chan_on
    // lane count for the single, dual or quad variant
    function automatic int pick(input logic [1:0] v, input int n_single, input int n_dual, input int n_quad);
        unique case (v)
            SLFM_VAR_QUAD: pick = n_quad;
            SLFM_VAR_DUAL: pick = n_dual;
            default:       pick = n_single;
        endcase
    endfunction : pick
    // lanes per mode and variant
    function automatic int lanes_used(input logic [3:0] m, input logic [1:0] v);
        unique case (m)
            SLFM_MODE0:             lanes_used = pick(v, 2, 4, 8);
            SLFM_MODE1, SLFM_MODE6: lanes_used = pick(v, 2, 3, 6);
            SLFM_MODE2, SLFM_MODE3: lanes_used = pick(v, 1, 2, 4);
            SLFM_MODE4:             lanes_used = pick(v, 1, 2, 3);
            SLFM_MODE5:             lanes_used = pick(v, 1, 1, 2);
            default:                lanes_used = 0;
        endcase
    endfunction : lanes_used

    ////////////////////////////////////////////////////////////////////////////
    // frame build; every frame is left-justified, unused bits zero
    always_comb begin
        int nl;
        nl = lanes_used(link_mode_select, chan_variant);
        map_frame = '0;
        unique case (link_mode_select)
            SLFM_MODE0: begin
                for (int ln = 0; ln < SLFM_LANES; ln++) begin
                    map_frame.lane[ln] = {s12(smp_data, ln/2, ln%2),
                                          s12(smp_data, ln/2, ln%2 + 2),
                                          s12(smp_data, ln/2, ln%2 + 4),
                                          s12(smp_data, ln/2, ln%2 + 6),
                                          s12(smp_data, ln/2, ln%2 + 8),
                                          SLFM_TAIL}; // tail zero
                end
            end
            // modes 1 and 6 packing, C/D repeat A/B
            SLFM_MODE1, SLFM_MODE6: begin
                // g picks the A/B or C/D group; bit selects index the beat itself,
                // since a select on a function result is not legal
                for (int g = 0; g < 2; g++) begin
                    map_frame.lane[3*g][63:48]   = {smp_data.smp[2*g][0], smp_data.smp[2*g][1][11:8]};
                    map_frame.lane[3*g+1][63:48] = {smp_data.smp[2*g][1][7:0],
                        (chan_on(chan_variant, 2*g+1) ? smp_data.smp[2*g+1][0][11:4] : SLFM_FILL8)};
                    map_frame.lane[3*g+2][63:48] = {smp_data.smp[2*g+1][0][3:0], smp_data.smp[2*g+1][1]};
                end
            end
            SLFM_MODE2: begin
                for (int ln = 0; ln < SLFM_CHANS; ln++)
                    map_frame.lane[ln][63:56] = s8(smp_data, ln, 0);
            end
            SLFM_MODE3: begin
                for (int ln = 0; ln < SLFM_CHANS; ln++)
                    map_frame.lane[ln][63:24] = {s10(smp_data, ln, 0), s10(smp_data, ln, 1),
                                                 s10(smp_data, ln, 2), s10(smp_data, ln, 3)};
            end
            SLFM_MODE4: begin
                map_frame.lane[0][63:48] = {smp_data.smp[0][0],
                    (chan_on(chan_variant, 1) ? smp_data.smp[1][0][11:8] : SLFM_FILL4)};
                // dual has no channel C, so the second lane ends in zero fill
                map_frame.lane[1][63:48] = {smp_data.smp[1][0][7:0],
                    (chan_on(chan_variant, 2) ? smp_data.smp[2][0][11:4] : SLFM_FILL8)};
                map_frame.lane[2][63:48] = {smp_data.smp[2][0][3:0], smp_data.smp[3][0]};
            end
            SLFM_MODE5: begin
                map_frame.lane[0][63:48] = {s8(smp_data, 0, 0),
                    (chan_on(chan_variant, 1) ? s8(smp_data, 1, 0) : SLFM_FILL8)};
                map_frame.lane[1][63:48] = {s8(smp_data, 2, 0), s8(smp_data, 3, 0)};
            end
            default: map_frame = '0;
        endcase
        for (int ln = 0; ln < SLFM_LANES; ln++) begin
            map_frame.lane_en[ln] = (ln < nl);
            if (ln >= nl) map_frame.lane[ln] = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame buffer; back-pressure stalls the sample source
    slfm_fifo #(
        .WIDTH ($bits(slfm_frame_t)),
        .DEPTH (SLFM_FIFO_DEP)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (take),
        .in_ready  (),
        .in_data   (map_frame),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_frame)
    );

    ////////////////////////////////////////////////////////////////////////////
    // the buffer's own ready is gates after its count; a mirror count gives a
    // registered ready instead, so every top-level output leaves a flop
    assign take      = smp_valid && st.in_rdy;
    assign smp_ready = st.in_rdy;

    // output stage: registered so all outputs come from flops
    assign fifo_pop = fifo_valid && (!st.out_vld || frame_ready);
    always_comb begin
        next_st = st;
        if (st.out_vld && frame_ready) next_st.out_vld = 1'b0;
        if (fifo_pop) begin
            next_st.out_vld = 1'b1;
            next_st.out     = fifo_frame;
        end
        // mirror count moves with every push and pop of the buffer
        next_st.used   = st.used + OCC_W'(take) - OCC_W'(fifo_pop);
        // ready looks at the next count, so a beat beyond the depth is refused at once
        next_st.in_rdy = (next_st.used != OCC_FULL);
    end

    // async reset loads the idle constant only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) st <= ST_IDLE;
        else        st <= next_st;
    end

    // lane outputs straight from the output flop
    assign frame_valid = st.out_vld;
    assign lane_enable = st.out.lane_en;
    assign lane_data   = st.out.lane;
endmodule : slfm_mapper
`default_nettype wire

// >>> bench/slfm_mapper_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module slfm_mapper_chk
    import slfm_pkg::*;
(
    input wire logic                                 clk_sys,
    input wire logic                                 rst_n,
    input wire logic [3:0]                           link_mode_select,
    input wire logic [1:0]                           chan_variant,
    input wire slfm_beat_t                           smp_data,
    input wire logic                                 smp_valid,
    input wire logic                                 smp_ready,
    input wire logic                                 frame_ready,
    input wire logic                                 frame_valid,
    input wire logic [SLFM_LANES-1:0]                lane_enable,
    input wire logic [SLFM_LANES-1:0][SLFM_FRAME_W-1:0] lane_data
);
    logic [63:0] pad;
    logic        off_ok;
    logic        pad_ok;
    // bits below each mode's frame width must stay zero
    always_comb begin
        pad = (link_mode_select == SLFM_MODE0) ? 64'hF : (link_mode_select == SLFM_MODE2) ? 64'hFF_FFFF_FFFF_FFFF :
              (link_mode_select == SLFM_MODE3) ? 64'hFF_FFFF : 64'hFFFF_FFFF_FFFF;
        off_ok = 1'b1;
        pad_ok = 1'b1;
        for (int l = 0; l < SLFM_LANES; l++) begin
            off_ok &= lane_enable[l] || (lane_data[l] == 64'h0);
            pad_ok &= ((lane_data[l] & pad) == 64'h0);
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    stall_hold_a: assert property (
        frame_valid && !frame_ready |=> frame_valid && $stable(lane_data) && $stable(lane_enable))
        else $error("frame moved in stall");
    take_lat_a: assert property (
        smp_valid && smp_ready && !frame_valid |-> ##[1:2] frame_valid)
        else $error("frame late");
    reset_idle_a: assert property (
        $rose(rst_n) |-> !frame_valid && lane_enable == 8'h0 && smp_ready)
        else $error("not idle");
    off_zero_a: assert property (off_ok) else $error("idle lane carries data");
    low_lanes_a: assert property (((lane_enable + 8'h1) & lane_enable) == 8'h0) else $error("lane gap");
    single_lanes_a: assert property (
        frame_valid && chan_variant == SLFM_VAR_SINGLE |-> lane_enable[7:2] == 6'h0)
        else $error("single lanes");
    dual_lanes_a: assert property (
        frame_valid && chan_variant == SLFM_VAR_DUAL |-> lane_enable[7:4] == 4'h0)
        else $error("dual lanes");
    bad_mode_a: assert property (
        frame_valid && link_mode_select > SLFM_MODE6 |-> lane_enable == 8'h0)
        else $error("bad mode lanes");
    pad_zero_a: assert property (frame_valid |-> pad_ok) else $error("tail or pad not zero");
    cover property (frame_valid && !frame_ready);
    cover property (smp_valid && !smp_ready);
    cover property (frame_valid && lane_enable == 8'hFF);
endmodule : slfm_mapper_chk
bind slfm_mapper slfm_mapper_chk u_chk (.*);
`default_nettype wire

// >>> bench/slfm_sink.sv
`timescale 1ns/10ps
`default_nettype none
module slfm_sink (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              hold,
    input  wire logic              slow,
    input  wire logic              frame_valid,
    input  wire logic [7:0]        lane_enable,
    input  wire logic [7:0][63:0]  lane_data,
    output logic                   frame_ready,
    output logic                   got,
    output logic [7:0]             cap_en,
    output logic [7:0][63:0]       cap_data
);
    logic ph;
    // slow mode takes a frame every other cycle only
    assign frame_ready = !hold && (!slow || ph);
    // capture all lanes together, on every cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ph <= 1'b0;
            got <= 1'b0;
        end else begin
            ph <= !ph;
            got <= frame_valid && frame_ready;
            cap_en <= lane_enable;
            cap_data <= lane_data;
        end
    end
endmodule : slfm_sink
`default_nettype wire

// >>> bench/sample_lane_frame_mapper_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
    $display("unexpected %s expected %h seen %h", n, e, a); end end
module sample_lane_frame_mapper_tb;
    import slfm_pkg::*;
    logic clk_sys = 0, rst_n = 0, hold = 0, slow = 0, smp_valid = 0, frame_valid, smp_ready, frame_ready, got;
    logic [3:0] link_mode_select = 4'h0;
    logic [1:0] chan_variant = 2'h0;
    slfm_beat_t smp_data = '0;
    logic [7:0] lane_enable, cap_en;
    logic [7:0][63:0] lane_data, cap_data;
    int fail_count = 0, samples_checked = 0, seq = 0;
    int ln [8][3] = '{'{2, 4, 8}, '{2, 3, 6}, '{1, 2, 4}, '{1, 2, 4}, '{1, 2, 3}, '{1, 1, 2}, '{2, 3, 6}, '{0, 0, 0}};
    slfm_frame_t q[$], f;
    always #2.5 clk_sys = !clk_sys;
    slfm_mapper u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .link_mode_select(link_mode_select), .chan_variant(chan_variant),
        .smp_data(smp_data), .smp_valid(smp_valid), .smp_ready(smp_ready), .frame_ready(frame_ready),
        .frame_valid(frame_valid), .lane_enable(lane_enable), .lane_data(lane_data));
    slfm_sink u_sink (.clk_sys(clk_sys), .rst_n(rst_n), .hold(hold), .slow(slow), .frame_valid(frame_valid),
        .lane_enable(lane_enable), .lane_data(lane_data), .frame_ready(frame_ready), .got(got), .cap_en(cap_en),
        .cap_data(cap_data));
    // expected lanes; channels beyond the variant read as zero fill
    function automatic slfm_frame_t expect_f(input logic [3:0] m, input int v, input int nl, input int r);
        slfm_smp_t s [4][10];
        logic [47:0] st;
        slfm_frame_t e;
        int nc;
        nc = (v == 2) ? 4 : (v == 1) ? 2 : 1;
        e = '0;
        for (int c = 0; c < 4; c++)
            for (int n = 0; n < 10; n++)
                s[c][n] = (c < nc) ? 12'((c * 10 + n + 1) * 61 + r * 7) : 12'h0;
        for (int l = 0; l < nl; l++) begin
            e.lane_en[l] = 1'b1;
            st = (m == SLFM_MODE4) ? {s[0][0], s[1][0], s[2][0], s[3][0]}
                                   : {s[l/3*2%4][0], s[l/3*2%4][1], s[(l/3*2+1)%4][0], s[(l/3*2+1)%4][1]};
            case (m)
                SLFM_MODE0: e.lane[l] = {s[l/2][l%2], s[l/2][l%2+2], s[l/2][l%2+4], s[l/2][l%2+6], s[l/2][l%2+8], 4'h0};
                SLFM_MODE2: e.lane[l] = {s[l][0][11:4], 56'h0};
                SLFM_MODE3: e.lane[l] = {s[l][0][11:2], s[l][1][11:2], s[l][2][11:2], s[l][3][11:2], 24'h0};
                SLFM_MODE5: e.lane[l] = {s[2*l][0][11:4], s[2*l+1][0][11:4], 48'h0};
                default: e.lane[l] = {st[47-16*(l%3) -: 16], 48'h0};
            endcase
        end
        return e;
    endfunction : expect_f
    task automatic wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    // offer one beat, held until taken
    task automatic push(input int nl);
        int k;
        for (int c = 0; c < 4; c++)
            for (int n = 0; n < 10; n++)
                smp_data.smp[c][n] = 12'((c * 10 + n + 1) * 61 + seq * 7);
        smp_valid = 1'b1;
        for (k = 0; smp_ready !== 1'b1 && k < 50; k++) begin @(posedge clk_sys); #1; end
        if (k == 50) begin fail_count++; wrap_up(); end
        @(posedge clk_sys);
        #1 q.push_back(expect_f(link_mode_select, chan_variant, nl, seq));
        seq++;
    endtask : push
    task automatic drain;
        int k;
        for (k = 0; q.size() > 0 && k < 300; k++) @(posedge clk_sys);
        if (k == 300) begin fail_count++; wrap_up(); end
        // leave the edge before the caller touches any input
        #1;
    endtask : drain
    // every frame the sink takes must match the next expected one
    always @(posedge clk_sys) begin
        #1 if (got === 1'b1 && q.size() > 0) begin
            f = q.pop_front();
            `CHK("lane_enable", f.lane_en, cap_en)
            `CHK("lane_data", f.lane, cap_data)
        end
        else if (got === 1'b1) `CHK("frame without beat", 1'b0, got)
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        `CHK("idle lanes", 8'h0, lane_enable)
        for (int m = 0; m < 8; m++) for (int v = 0; v < 3; v++) begin
            link_mode_select = 4'(m);
            chan_variant = 2'(v);
            slow = v[0];
            push(ln[m][v]);
            smp_valid = 1'b0;
            drain();
            $display("row mode %0d variant %0d done", m, v);
        end
        link_mode_select = SLFM_MODE0;
        chan_variant = SLFM_VAR_QUAD;
        hold = 1'b1;
        for (int k = 0; k < 12 && smp_ready === 1'b1; k++) push(8);
        `CHK("beats stored", 1'b1, q.size() == 8 || q.size() == 9)
        repeat (3) @(posedge clk_sys);
        #1 smp_valid = 1'b0;
        hold = 1'b0;
        drain();
        $display("fill and drain done");
        hold = 1'b1;
        push(8);
        smp_valid = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 rst_n = 1'b0;
        q.delete();
        @(posedge clk_sys);
        #1 rst_n = 1'b1;
        `CHK("valid after reset", 1'b0, frame_valid)
        hold = 1'b0;
        push(8);
        smp_valid = 1'b0;
        drain();
        $display("mid-run reset done");
        wrap_up();
    end
endmodule : sample_lane_frame_mapper_tb
`default_nettype wire
